// *** hw/ecmc_defs.vh ***
`ifndef ECMC_DEFS_VH
`define ECMC_DEFS_VH
// Register indices, byte address is four times the index
`define ECMC_IDX_MAIN0    12'h400
`define ECMC_IDX_MAIN1    12'h401
`define ECMC_IDX_IRQ_STAT 12'h420
`define ECMC_IDX_IRQ_MASK 12'h421
`define ECMC_IDX_STATUS   12'h422
// Main control field positions
`define ECMC_BIT_PWR   0
`define ECMC_BIT_LAW   1
`define ECMC_BIT_FMT   2
`define ECMC_BIT_TA    3
`define ECMC_BIT_TB    4
`define ECMC_BIT_GMASK 5
`define ECMC_BIT_OE    6
// Reset values and writable bits
`define ECMC_MAIN_RST     8'h00
`define ECMC_MAIN0_WMASK  8'h7f
`define ECMC_MAIN1_WMASK  8'h1f
`define ECMC_IRQ_MASK_RST 6'h00
`define ECMC_IRQ_W        6
`define ECMC_IRQ_INIT0    4
// Initialization length in frames
`define ECMC_INIT_FRAMES  2'd2
// Bus responses
`define ECMC_RESP_OKAY    2'b00
`define ECMC_RESP_SLVERR  2'b10
`endif

// *** hw/ecmc_group.v ***
`timescale 1ns/10ps
`include "ecmc_defs.vh"
module ecmc_group #(
  parameter W = 8
) (
  input  wire         clk_i,       // Clock
  input  wire         rst_i,       // Sync reset
  input  wire         frame_i,     // Frame tick
  input  wire         pwr_i,       // Group power-on
  input  wire [W-1:0] rin_i,       // Receive in
  input  wire [W-1:0] sin_i,       // Send in
  input  wire [W-1:0] ec_rout_i,   // Canceller receive out
  input  wire [W-1:0] ec_sout_i,   // Canceller send out
  output reg  [W-1:0] rout_o,      // Receive out
  output reg  [W-1:0] sout_o,      // Send out
  output reg          init_o,      // Init running
  output reg          done_o       // Init done pulse
);
  reg [W-1:0] r1_ff, r2_ff, s1_ff, s2_ff;
  reg         pwr_d_ff;
  reg [1:0]   cnt_ff;

  // Two frame bypass line and output select
  always @(posedge clk_i) begin
    if (rst_i) begin
      r1_ff  <= {W{1'b0}};
      r2_ff  <= {W{1'b0}};
      s1_ff  <= {W{1'b0}};
      s2_ff  <= {W{1'b0}};
      rout_o <= {W{1'b0}};
      sout_o <= {W{1'b0}};
    end else begin
      if (frame_i) begin
        r1_ff <= rin_i;
        r2_ff <= r1_ff;
        s1_ff <= sin_i;
        s2_ff <= s1_ff;
      end
      if (pwr_i) begin
        rout_o <= ec_rout_i;
        sout_o <= ec_sout_i;
      end else if (frame_i) begin
        rout_o <= r2_ff;
        sout_o <= s2_ff;
      end
    end
  end

  // Init run on power-on rising edge, lasts two frames
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_d_ff <= 1'b0;
      cnt_ff   <= 2'd0;
      init_o   <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      pwr_d_ff <= pwr_i;
      done_o   <= 1'b0;
      if (!pwr_i) begin
        cnt_ff <= 2'd0;
        init_o <= 1'b0;
      end else if (!pwr_d_ff) begin
        cnt_ff <= `ECMC_INIT_FRAMES;
        init_o <= 1'b1;
      end else if (frame_i && cnt_ff != 2'd0) begin
        cnt_ff <= cnt_ff - 2'd1;
        if (cnt_ff == 2'd1) begin
          init_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule // ecmc_group

// *** hw/ecmc_sync2.v ***
`timescale 1ns/10ps
module ecmc_sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,  // Clock
  input  wire         rst_i,  // Sync reset
  input  wire [W-1:0] d_i,    // Async level
  output reg  [W-1:0] q_o     // Synchronised level
);
  reg [W-1:0] meta_ff;

  // Two flop synchroniser
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= {W{1'b0}};
      q_o     <= {W{1'b0}};
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule // ecmc_sync2

// *** hw/ecmc_top.v ***
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "ecmc_defs.vh"
module ecmc_top #(
  parameter W  = 8,
  parameter AW = 14
) (
  input  wire           ref_clk_i,        // 25 MHz clock
  input  wire           rst_i,            // Sync reset, high
  input  wire [AW-1:0]  s_axi_awaddr_i,   // Write address
  input  wire           s_axi_awvalid_i,  // Write address valid
  output reg            s_axi_awready_o,  // Write address ready
  input  wire [31:0]    s_axi_wdata_i,    // Write data
  input  wire [3:0]     s_axi_wstrb_i,    // Write strobes
  input  wire           s_axi_wvalid_i,   // Write data valid
  output reg            s_axi_wready_o,   // Write data ready
  output reg  [1:0]     s_axi_bresp_o,    // Write response
  output reg            s_axi_bvalid_o,   // Write response valid
  input  wire           s_axi_bready_i,   // Write response ready
  input  wire [AW-1:0]  s_axi_araddr_i,   // Read address
  input  wire           s_axi_arvalid_i,  // Read address valid
  output reg            s_axi_arready_o,  // Read address ready
  output reg  [31:0]    s_axi_rdata_o,    // Read data
  output reg  [1:0]     s_axi_rresp_o,    // Read response
  output reg            s_axi_rvalid_o,   // Read data valid
  input  wire           s_axi_rready_i,   // Read data ready
  input  wire           oe_pin_i,         // Output enable pin
  input  wire           frame_i,          // Frame tick, one cycle
  input  wire [2*W-1:0] rin_i,            // Receive in, per group
  input  wire [2*W-1:0] sin_i,            // Send in, per group
  input  wire [2*W-1:0] ec_rout_i,        // Canceller receive out
  input  wire [2*W-1:0] ec_sout_i,        // Canceller send out
  input  wire [3:0]     tone_evt_i,       // Tone events g0A g0B g1A g1B
  output wire [2*W-1:0] rout_o,           // Receive out, per group
  output wire [2*W-1:0] sout_o,           // Send out, per group
  output reg            rout_oe_n_o,      // Receive out enable, low
  output reg            sout_oe_n_o,      // Send out enable, low
  output reg  [1:0]     ec_active_o,      // Cancellers active
  output wire [1:0]     ec_init_o,        // Init running
  output reg  [1:0]     pcm_g711_o,       // Code select
  output reg  [1:0]     pcm_law_o,        // Law select
  output reg            irq_o             // Interrupt, high
);
  // Control and interrupt registers
  reg [7:0]               main0_ff;
  reg [7:0]               main1_ff;
  reg [`ECMC_IRQ_W-1:0]   irq_stat_ff;
  reg [`ECMC_IRQ_W-1:0]   irq_mask_ff;
  reg [`ECMC_IRQ_W-1:0]   nxt_irq_stat;
  // Write channel holding
  reg                     aw_hold_ff;
  reg                     w_hold_ff;
  reg [11:0]              awidx_ff;
  reg [31:0]              wdata_ff;
  reg [3:0]               wstrb_ff;
  // Decode helpers
  wire                    oe_pin_s;
  wire [1:0]              init_done;
  wire                    aw_hs;
  wire                    w_hs;
  wire                    have_aw;
  wire                    have_w;
  wire                    do_wr;
  wire                    ar_hs;
  wire [11:0]             wr_idx;
  wire [31:0]             wr_data;
  wire [3:0]              wr_strb;
  wire                    wr_lo;
  wire [11:0]             rd_idx;
  reg  [31:0]             rd_val;
  reg                     rd_ok;
  reg                     wr_ok;
  wire [3:0]              tone_ok;
  wire [`ECMC_IRQ_W-1:0]  irq_set;
  wire [1:0]              pwr;

  // External enable pin resynchronised
  ecmc_sync2 #(
    .W (1)
  ) u_oe_sync (
    .clk_i (ref_clk_i),
    .rst_i (rst_i),
    .d_i   (oe_pin_i),
    .q_o   (oe_pin_s)
  );

  assign pwr = {main1_ff[`ECMC_BIT_PWR], main0_ff[`ECMC_BIT_PWR]};

  // One datapath and init sequencer per group
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_grp
      ecmc_group #(
        .W (W)
      ) u_grp (
        .clk_i     (ref_clk_i),
        .rst_i     (rst_i),
        .frame_i   (frame_i),
        .pwr_i     (pwr[g]),
        .rin_i     (rin_i[g*W +: W]),
        .sin_i     (sin_i[g*W +: W]),
        .ec_rout_i (ec_rout_i[g*W +: W]),
        .ec_sout_i (ec_sout_i[g*W +: W]),
        .rout_o    (rout_o[g*W +: W]),
        .sout_o    (sout_o[g*W +: W]),
        .init_o    (ec_init_o[g]),
        .done_o    (init_done[g])
      );
    end
  endgenerate

  // Write channel handshakes
  assign aw_hs   = s_axi_awvalid_i & s_axi_awready_o;
  assign w_hs    = s_axi_wvalid_i & s_axi_wready_o;
  assign have_aw = aw_hs | aw_hold_ff;
  assign have_w  = w_hs | w_hold_ff;
  assign do_wr   = have_aw & have_w & ~s_axi_bvalid_o;
  assign wr_idx  = aw_hs ? s_axi_awaddr_i[13:2] : awidx_ff;
  assign wr_data = w_hs ? s_axi_wdata_i : wdata_ff;
  assign wr_strb = w_hs ? s_axi_wstrb_i : wstrb_ff;
  assign wr_lo   = do_wr & wr_strb[0];

  // Write address decode
  always @* begin
    case (wr_idx)
      `ECMC_IDX_MAIN0,
      `ECMC_IDX_MAIN1,
      `ECMC_IDX_IRQ_STAT,
      `ECMC_IDX_IRQ_MASK,
      `ECMC_IDX_STATUS:   wr_ok = 1'b1;
      default:            wr_ok = 1'b0;
    endcase
  end

  // Write address and data capture, response
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_hold_ff      <= 1'b0;
      w_hold_ff       <= 1'b0;
      awidx_ff        <= 12'h000;
      wdata_ff        <= 32'h00000000;
      wstrb_ff        <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `ECMC_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_hold_ff      <= 1'b1;
        awidx_ff        <= s_axi_awaddr_i[13:2];
        s_axi_awready_o <= 1'b0;
      end
      if (w_hs) begin
        w_hold_ff      <= 1'b1;
        wdata_ff       <= s_axi_wdata_i;
        wstrb_ff       <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_wr) begin
        aw_hold_ff     <= 1'b0;
        w_hold_ff      <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_ok ? `ECMC_RESP_OKAY : `ECMC_RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Main control registers; group one lacks enable and global mask
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      main0_ff    <= `ECMC_MAIN_RST;
      main1_ff    <= `ECMC_MAIN_RST;
      irq_mask_ff <= `ECMC_IRQ_MASK_RST;
    end else if (wr_lo) begin
      if (wr_idx == `ECMC_IDX_MAIN0) begin
        main0_ff <= wr_data[7:0] & `ECMC_MAIN0_WMASK;
      end
      if (wr_idx == `ECMC_IDX_MAIN1) begin
        main1_ff <= wr_data[7:0] & `ECMC_MAIN1_WMASK;
      end
      if (wr_idx == `ECMC_IDX_IRQ_MASK) begin
        irq_mask_ff <= wr_data[`ECMC_IRQ_W-1:0];
      end
    end
  end

  // Tone event gating by global and per detector masks
  assign tone_ok[0] = ~main0_ff[`ECMC_BIT_GMASK] & ~main0_ff[`ECMC_BIT_TA];
  assign tone_ok[1] = ~main0_ff[`ECMC_BIT_GMASK] & ~main0_ff[`ECMC_BIT_TB];
  assign tone_ok[2] = ~main0_ff[`ECMC_BIT_GMASK] & ~main1_ff[`ECMC_BIT_TA];
  assign tone_ok[3] = ~main0_ff[`ECMC_BIT_GMASK] & ~main1_ff[`ECMC_BIT_TB];
  assign irq_set    = {init_done, tone_evt_i & tone_ok & {pwr[1], pwr[1], pwr[0], pwr[0]}};

  // Sticky status, write one clears, set beats clear
  always @* begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_lo && wr_idx == `ECMC_IDX_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~wr_data[`ECMC_IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | irq_set;
  end

  // Status and interrupt line
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= {`ECMC_IRQ_W{1'b0}};
      irq_o       <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_o       <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  // Datapath controls to the cancellers and output drivers
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rout_oe_n_o <= 1'b1;
      sout_oe_n_o <= 1'b1;
      ec_active_o <= 2'b00;
      pcm_g711_o  <= 2'b00;
      pcm_law_o   <= 2'b00;
    end else begin
      rout_oe_n_o <= ~(main0_ff[`ECMC_BIT_OE] & oe_pin_s);
      sout_oe_n_o <= ~(main0_ff[`ECMC_BIT_OE] & oe_pin_s);
      ec_active_o <= pwr;
      pcm_g711_o  <= {main1_ff[`ECMC_BIT_FMT], main0_ff[`ECMC_BIT_FMT]};
      pcm_law_o   <= {main1_ff[`ECMC_BIT_LAW], main0_ff[`ECMC_BIT_LAW]};
    end
  end

  // Read decode
  assign ar_hs  = s_axi_arvalid_i & s_axi_arready_o;
  assign rd_idx = s_axi_araddr_i[13:2];

  always @* begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (rd_idx)
      `ECMC_IDX_MAIN0:    rd_val[7:0] = main0_ff;
      `ECMC_IDX_MAIN1:    rd_val[7:0] = main1_ff;
      `ECMC_IDX_IRQ_STAT: rd_val[`ECMC_IRQ_W-1:0] = irq_stat_ff;
      `ECMC_IDX_IRQ_MASK: rd_val[`ECMC_IRQ_W-1:0] = irq_mask_ff;
      `ECMC_IDX_STATUS:   rd_val[5:0] = {~rout_oe_n_o, oe_pin_s,
                                         ec_active_o, ec_init_o};
      default:            rd_ok = 1'b0;
    endcase
  end

  // Read channel
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h00000000;
      s_axi_rresp_o   <= `ECMC_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_val;
      s_axi_rresp_o   <= rd_ok ? `ECMC_RESP_OKAY : `ECMC_RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
    end
  end
endmodule // ecmc_top

// *** testbench/ecmc_pcm_src.sv ***
`timescale 1ns/10ps
module ecmc_pcm_src #(
  parameter FRM = 16
) (
  input  wire        ref_clk_i,        // Clock
  input  wire        rst_i,            // Sync reset
  output reg         frame_o = 1'b0,   // Frame tick
  output reg  [15:0] rin_o = 16'h0000, // Receive stream
  output reg  [15:0] sin_o = 16'h0000  // Send stream
);
  localparam [4:0] LAST = FRM - 1;
  reg [4:0]  cnt_ff;
  reg [15:0] lfsr_ff;

  // Frame tick and a new sample after each tick, so delays show
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_ff  <= 5'h00;
      frame_o <= 1'b0;
      lfsr_ff <= 16'hace1;
    end else begin
      cnt_ff  <= (cnt_ff == LAST) ? 5'h00 : cnt_ff + 5'h01;
      frame_o <= (cnt_ff == LAST);
      if (frame_o) begin
        lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
        rin_o   <= lfsr_ff;
        sin_o   <= {lfsr_ff[7:0], ~lfsr_ff[15:8]};
      end
    end
  end
endmodule // ecmc_pcm_src

// *** testbench/ecmc_top_assertions.sv ***
`timescale 1ns/10ps
module ecmc_chk #(
  parameter W  = 8,
  parameter AW = 14
) (
  input wire           ref_clk_i,        // Clock
  input wire           rst_i,            // Sync reset
  input wire           oe_pin_i,         // Enable pin
  input wire           frame_i,          // Frame tick
  input wire [2*W-1:0] rin_i,            // Receive in
  input wire [2*W-1:0] sin_i,            // Send in
  input wire [2*W-1:0] ec_rout_i,        // Canceller receive out
  input wire [2*W-1:0] ec_sout_i,        // Canceller send out
  input wire           s_axi_awready_o,  // Write address ready
  input wire           s_axi_wready_o,   // Write data ready
  input wire [1:0]     s_axi_bresp_o,    // Write response
  input wire           s_axi_bvalid_o,   // Write response valid
  input wire           s_axi_bready_i,   // Write response ready
  input wire [31:0]    s_axi_rdata_o,    // Read data
  input wire [1:0]     s_axi_rresp_o,    // Read response
  input wire           s_axi_rvalid_o,   // Read valid
  input wire           s_axi_rready_i,   // Read ready
  input wire [2*W-1:0] rout_o,           // Receive out
  input wire [2*W-1:0] sout_o,           // Send out
  input wire           rout_oe_n_o,      // Receive enable, low
  input wire           sout_oe_n_o,      // Send enable, low
  input wire [1:0]     ec_active_o,      // Groups active
  input wire [1:0]     ec_init_o         // Init running
);
  reg [W-1:0] h1r_ff, h2r_ff, h1s_ff, h2s_ff;
  reg [1:0]   dn_ff, ic_ff;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Frame history, powered-down tick count, init tick count
  always @(posedge ref_clk_i) begin
    if (rst_i || ec_active_o[1])
      dn_ff <= 2'd0;
    else if (frame_i && dn_ff != 2'd3)
      dn_ff <= dn_ff + 2'd1;
    if (rst_i || !ec_init_o[0])
      ic_ff <= 2'd0;
    else if (frame_i)
      ic_ff <= ic_ff + 2'd1;
    if (frame_i) begin
      h1r_ff <= rin_i[2*W-1:W];
      h2r_ff <= h1r_ff;
      h1s_ff <= sin_i[2*W-1:W];
      h2s_ff <= h1s_ff;
    end
  end

  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable({s_axi_rresp_o, s_axi_rdata_o})) else $error("read data unstable");
  a_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  a_oe_pair: assert property (rout_oe_n_o == sout_oe_n_o) else $error("enables differ");
  a_oe_pin: assert property (!oe_pin_i [*4] |=> rout_oe_n_o)
    else $error("outputs driven with pin low");
  a_bypass_delay: assert property (frame_i && !ec_active_o[1] && dn_ff == 2'd3 ##1
    !ec_active_o[1] |-> rout_o[2*W-1:W] == $past(h2r_ff) &&
    sout_o[2*W-1:W] == $past(h2s_ff))
    else $error("bypass data not two frames late");
  a_ec_path: assert property ((ec_active_o[0] && !ec_init_o[0]) [*3] |->
    rout_o[W-1:0] == $past(ec_rout_i[W-1:0]) && sout_o[W-1:0] == $past(ec_sout_i[W-1:0]))
    else $error("active group not passing canceller data");
  a_init_end: assert property ($fell(ec_init_o[0]) && ec_active_o[0] |->
    $past(frame_i) && ic_ff != 2'd0 && ic_ff != 2'd3) else $error("init ended off frame");
  a_init_short: assert property (ec_init_o[0] |-> ic_ff < 2'd2)
    else $error("init longer than two frames");
endmodule // ecmc_chk

// *** testbench/tb_ecmc_top.sv ***
`timescale 1ns/10ps
`include "ecmc_defs.vh"
module tb_ecmc_top;
  localparam W = 8;
  localparam AW = 14;
  localparam CEIL = 20000;
  localparam [1:0] OK = `ECMC_RESP_OKAY;
  localparam [1:0] SE = `ECMC_RESP_SLVERR;
  reg           ref_clk_i = 1'b0, rst_i = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
  reg           bready = 1'b0, arvalid = 1'b0, rready = 1'b0, oe_pin = 1'b0;
  reg  [AW-1:0] awaddr = '0, araddr = '0;
  reg  [31:0]   wdata = 32'h0, seed = 32'hc4d0ca85;
  reg  [3:0]    wstrb = 4'h0, tone = 4'h0;
  reg  [15:0]   ec_rout = 16'h0, ec_sout = 16'h0;
  wire          awready, wready, bvalid, arready, rvalid, rout_oe_n, sout_oe_n, irq, frame;
  wire [1:0]    bresp, rresp, ec_active, ec_init, pcm_g711, pcm_law;
  wire [31:0]   rdata;
  wire [15:0]   rout, sout, rin, sin;
  reg  [33:0]   bq[$], rq[$];
  integer       n_mismatch = 0, samples_checked = 0, cyc = 0, i;

  always #20 ref_clk_i = ~ref_clk_i;

  ecmc_pcm_src #(.FRM(16)) ecmc_pcm_src_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .frame_o(frame), .rin_o(rin), .sin_o(sin));

  ecmc_top #(.W(W), .AW(AW)) ecmc_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .oe_pin_i(oe_pin), .frame_i(frame),
    .rin_i(rin), .sin_i(sin), .ec_rout_i(ec_rout), .ec_sout_i(ec_sout), .tone_evt_i(tone),
    .rout_o(rout), .sout_o(sout), .rout_oe_n_o(rout_oe_n), .sout_oe_n_o(sout_oe_n),
    .ec_active_o(ec_active), .ec_init_o(ec_init), .pcm_g711_o(pcm_g711),
    .pcm_law_o(pcm_law), .irq_o(irq));

  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task end_sim;
    begin
      if (n_mismatch == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  task cmp_bus(input [33:0] exp, input [33:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
    end
  endtask

  task cmp_lvl(input [7:0] got, input [7:0] exp);
    cmp_bus({26'h0, exp}, {26'h0, got});
  endtask

  // Write: address and data offered together, each released when taken
  task wr(input [11:0] idx, input [7:0] d, input [3:0] st, input [1:0] er);
    begin
      bq.push_back({er, 32'h0});
      @(posedge ref_clk_i);
      awaddr  <= {idx, 2'b00};
      wdata   <= {seed[31:8], d};
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
        @(posedge ref_clk_i);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
    end
  endtask

  task rd(input [11:0] idx, input [7:0] d, input [1:0] er);
    begin
      rq.push_back({er, 24'h0, d});
      @(posedge ref_clk_i);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
        @(posedge ref_clk_i);
        if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
    end
  endtask

  task settle;
    @(negedge ref_clk_i);
  endtask

  task wait_frames(input integer n);
    repeat (n) begin
      @(posedge ref_clk_i);
      while (frame !== 1'b1) @(posedge ref_clk_i);
    end
  endtask

  // Response monitor against the oldest note
  always @(posedge ref_clk_i) begin
    if (bvalid === 1'b1 && bready === 1'b1) cmp_bus(bq.pop_front(), {bresp, 32'h0});
    if (rvalid === 1'b1 && rready === 1'b1) cmp_bus(rq.pop_front(), {rresp, rdata});
  end

  // Random canceller data and hang limit
  always @(posedge ref_clk_i) begin
    seed = xs(seed);
    ec_rout <= seed[15:0];
    ec_sout <= seed[31:16];
    cyc = cyc + 1;
    if (cyc == CEIL) begin
      n_mismatch = n_mismatch + 1;
      end_sim;
    end
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // Reset values and field widths
    rd(`ECMC_IDX_MAIN0, 8'h00, OK);
    rd(`ECMC_IDX_MAIN1, 8'h00, OK);
    rd(`ECMC_IDX_IRQ_STAT, 8'h00, OK);
    rd(`ECMC_IDX_IRQ_MASK, 8'h00, OK);
    rd(`ECMC_IDX_STATUS, 8'h00, OK);
    wr(`ECMC_IDX_MAIN0, 8'hfe, 4'hf, OK);
    rd(`ECMC_IDX_MAIN0, 8'h7e, OK);
    wr(`ECMC_IDX_MAIN1, 8'hfe, 4'hf, OK);
    rd(`ECMC_IDX_MAIN1, 8'h1e, OK);
    wr(12'h3ff, 8'hff, 4'hf, SE);
    rd(12'h3ff, 8'h00, SE);
    wr(`ECMC_IDX_MAIN1, 8'h00, 4'he, OK);
    rd(`ECMC_IDX_MAIN1, 8'h1e, OK);
    wr(`ECMC_IDX_MAIN0, 8'h00, 4'hf, OK);
    wr(`ECMC_IDX_MAIN1, 8'h00, 4'hf, OK);
    // Power-up, init, interrupt raise and clear
    wr(`ECMC_IDX_MAIN0, 8'h01, 4'hf, OK);
    settle;
    cmp_lvl({7'h0, ec_init[0]}, 8'h01);
    wait_frames(2);
    settle;
    cmp_lvl({7'h0, ec_init[0]}, 8'h00);
    rd(`ECMC_IDX_IRQ_STAT, 8'h10, OK);
    rd(`ECMC_IDX_STATUS, 8'h04, OK);
    wr(`ECMC_IDX_IRQ_MASK, 8'h3f, 4'hf, OK);
    settle;
    cmp_lvl({7'h0, irq}, 8'h01);
    wr(`ECMC_IDX_IRQ_STAT, 8'h10, 4'hf, OK);
    settle;
    cmp_lvl({7'h0, irq}, 8'h00);
    // Output enable with pin
    wr(`ECMC_IDX_MAIN0, 8'h41, 4'hf, OK);
    settle;
    cmp_lvl({6'h0, rout_oe_n, sout_oe_n}, 8'h03);
    @(posedge ref_clk_i) oe_pin <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    settle;
    cmp_lvl({6'h0, rout_oe_n, sout_oe_n}, 8'h00);
    rd(`ECMC_IDX_STATUS, 8'h34, OK);
    @(posedge ref_clk_i) oe_pin <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    settle;
    cmp_lvl({6'h0, rout_oe_n, sout_oe_n}, 8'h03);
    @(posedge ref_clk_i) oe_pin <= 1'b1;
    wr(`ECMC_IDX_MAIN0, 8'h01, 4'hf, OK);
    repeat (5) @(posedge ref_clk_i);
    settle;
    cmp_lvl({6'h0, rout_oe_n, sout_oe_n}, 8'h03);
    // Every mask combination, group one powered down
    for (i = 0; i < 8; i = i + 1) begin
      wr(`ECMC_IDX_IRQ_STAT, 8'h3f, 4'hf, OK);
      wr(`ECMC_IDX_MAIN0, {2'b00, i[2], i[1], i[0], 3'b001}, 4'hf, OK);
      @(posedge ref_clk_i) tone <= 4'hf;
      @(posedge ref_clk_i) tone <= 4'h0;
      rd(`ECMC_IDX_IRQ_STAT, {6'h0, ~i[2] & ~i[1], ~i[2] & ~i[0]}, OK);
      settle;
      cmp_lvl({7'h0, irq}, {7'h0, ~i[2] & (~i[1] | ~i[0])});
    end
    // Code and law select per group
    wr(`ECMC_IDX_MAIN0, 8'h07, 4'hf, OK);
    wr(`ECMC_IDX_MAIN1, 8'h04, 4'hf, OK);
    settle;
    cmp_lvl({4'h0, pcm_g711, pcm_law}, 8'h0d);
    wr(`ECMC_IDX_MAIN0, 8'h01, 4'hf, OK);
    wr(`ECMC_IDX_MAIN1, 8'h00, 4'hf, OK);
    settle;
    cmp_lvl({4'h0, pcm_g711, pcm_law}, 8'h00);
    // Group one powered: own masks, init status
    wr(`ECMC_IDX_MAIN1, 8'h11, 4'hf, OK);
    @(posedge ref_clk_i) tone <= 4'hf;
    @(posedge ref_clk_i) tone <= 4'h0;
    rd(`ECMC_IDX_IRQ_STAT, 8'h07, OK);
    rd(`ECMC_IDX_STATUS, 8'h1e, OK);
    wait_frames(2);
    rd(`ECMC_IDX_IRQ_STAT, 8'h27, OK);
    // Second reset in mid-run
    @(posedge ref_clk_i) rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(`ECMC_IDX_MAIN0, 8'h00, OK);
    rd(`ECMC_IDX_IRQ_MASK, 8'h00, OK);
    settle;
    cmp_lvl({5'h0, rout_oe_n, sout_oe_n, irq}, 8'h06);
    end_sim;
  end
endmodule // tb_ecmc_top

bind ecmc_top ecmc_chk #(.W(W), .AW(AW)) ecmc_chk_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .oe_pin_i(oe_pin_i), .frame_i(frame_i), .rin_i(rin_i), .sin_i(sin_i),
  .ec_rout_i(ec_rout_i), .ec_sout_i(ec_sout_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .rout_o(rout_o),
  .sout_o(sout_o), .rout_oe_n_o(rout_oe_n_o), .sout_oe_n_o(sout_oe_n_o),
  .ec_active_o(ec_active_o), .ec_init_o(ec_init_o));
